// File: logic/pdts_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
module pdts_scheduler
    import pdts_pkg::*;
#(
    parameter int SAMPLE_CYCLES  = SAMPLE_CYCLES_DEF,
    parameter int INHIBIT_CYCLES = INHIBIT_CYCLES_DEF,
    parameter int CALC_CYCLES    = CALC_CYCLES_DEF
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [NODE_W-1:0] node_id,
    input  wire logic              sync_rx,
    input  wire logic              rtr_rx,
    input  wire logic              rtr_msg,
    input  wire pdts_obj_req_s     obj_req,
    output logic [31:0]            obj_rdata,
    output logic                   obj_ack,
    output logic                   obj_err,
    input  wire logic [31:0]       disc_position,
    output logic                   disc_sample,
    output pdts_tx_s               tx,
    input  wire logic              tx_ready
);
    typedef struct packed {
        pdts_boot_e                boot;
        pdts_msg_s [NMSG-1:0]      msg;
        logic [15:0]               cycle_time;
        logic [15:0]               cyc_cnt;
        logic [31:0]               raw;
        logic [31:0]               position;
        logic                      calc_busy;
        logic [CNT_W-1:0]          calc_cnt;
        logic                      calc_done;
        logic                      changed;
        logic                      sample;
        pdts_tx_s                  tx;
        logic [31:0]               rdata;
        logic                      ack;
        logic                      err;
        logic                      nv_we;
        logic [NV_W-1:0]           nv_wdata;
    } pdts_state_s;

    pdts_state_s     cur;
    pdts_state_s     next_cur;
    logic            tick_ms;
    logic            tick_inh;
    logic [NV_W-1:0] nv_rdata;
    logic            expire;
    logic            found;
    pdts_mode_e      cls;

    pdts_tick #(.PERIOD(SAMPLE_CYCLES)) u_tick_ms (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (tick_ms)
    );

    pdts_tick #(.PERIOD(INHIBIT_CYCLES)) u_tick_inh (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (tick_inh)
    );

    pdts_nvmem #(.W(NV_W), .DEPTH(NV_DEPTH), .AW(NV_AW)) u_nvmem (
        .clk   (clk),
        .we    (cur.nv_we),
        .waddr (NV_SLOT_INHIBIT1),
        .wdata (cur.nv_wdata),
        .raddr (NV_SLOT_INHIBIT1),
        .rdata (nv_rdata)
    );

    always_comb begin
        next_cur = cur;
        next_cur.sample = 1'b0;
        next_cur.calc_done = 1'b0;
        next_cur.changed = 1'b0;
        next_cur.ack = 1'b0;
        next_cur.err = 1'b0;
        next_cur.nv_we = 1'b0;
        expire = 1'b0;
        found = 1'b0;
        cls = MC_RESERVED;

        // Node number is read only once the reset is over, never under it
        unique case (cur.boot)
            BOOT_FETCH: begin
                next_cur.msg[0].cob = COB_BASE1 + COB_ID_W'(node_id);
                next_cur.msg[1].cob = COB_BASE2 + COB_ID_W'(node_id);
                next_cur.boot = BOOT_LOAD;
            end
            BOOT_LOAD: begin
                next_cur.msg[0].inhibit = nv_rdata;
                next_cur.boot = BOOT_RUN;
            end
            BOOT_RUN: begin
            end
        endcase

        // Disc read each millisecond, result valid after the calculation time
        if (tick_ms) begin
            next_cur.sample = 1'b1;
            next_cur.raw = disc_position;
            next_cur.calc_busy = 1'b1;
            next_cur.calc_cnt = '0;
        end else if (cur.calc_busy) begin
            if (cur.calc_cnt == CNT_W'(CALC_CYCLES - 1)) begin
                next_cur.calc_busy = 1'b0;
                next_cur.calc_done = 1'b1;
                next_cur.position = cur.raw;
                next_cur.changed = (cur.raw != cur.position);
            end else begin
                next_cur.calc_cnt = cur.calc_cnt + CNT_W'(1);
            end
        end

        // Device cycle timer in milliseconds, shared by both messages
        if (cur.cycle_time == '0) begin
            next_cur.cyc_cnt = '0;
        end else if (tick_ms) begin
            if (cur.cyc_cnt + 16'h0001 >= cur.cycle_time) begin
                next_cur.cyc_cnt = '0;
                expire = 1'b1;
            end else begin
                next_cur.cyc_cnt = cur.cyc_cnt + 16'h0001;
            end
        end

        for (int i = 0; i < NMSG; i++) begin
            cls = pdts_mode_class(cur.msg[i].mode);
            if (tick_inh && cur.msg[i].inh_cnt != '0)
                next_cur.msg[i].inh_cnt = cur.msg[i].inh_cnt - 17'h00001;
            if (sync_rx) begin
                unique case (cls)
                    MC_SYNC_CHG: begin
                        if (cur.position != cur.msg[i].last_sync)
                            next_cur.msg[i].wait_calc = 1'b1;
                        next_cur.msg[i].last_sync = cur.position;
                    end
                    MC_SYNC_CYC: begin
                        if (cur.msg[i].sync_cnt + 8'h01 >= cur.msg[i].mode) begin
                            next_cur.msg[i].sync_cnt = '0;
                            next_cur.msg[i].wait_calc = 1'b1;
                        end else begin
                            next_cur.msg[i].sync_cnt = cur.msg[i].sync_cnt + 8'h01;
                        end
                    end
                    MC_SYNC_LATCH: next_cur.msg[i].latched = cur.position;
                    MC_RESERVED, MC_RTR, MC_ASYNC: begin
                    end
                endcase
            end
            if (rtr_rx && rtr_msg == 1'(i)) begin
                unique case (cls)
                    MC_SYNC_CHG, MC_SYNC_CYC, MC_RTR: begin
                        next_cur.msg[i].wait_calc = 1'b1;
                        next_cur.msg[i].use_latch = 1'b0;
                    end
                    MC_SYNC_LATCH: begin
                        next_cur.msg[i].wait_calc = 1'b1;
                        next_cur.msg[i].use_latch = 1'b1;
                    end
                    MC_ASYNC: next_cur.msg[i].armed = 1'b1;
                    MC_RESERVED: begin
                    end
                endcase
            end
            // Triggered sends leave only once the running calculation has ended
            if (cur.calc_done && cur.msg[i].wait_calc) begin
                next_cur.msg[i].wait_calc = 1'b0;
                next_cur.msg[i].armed = 1'b1;
            end
            if (cls == MC_ASYNC) begin
                if (cur.cycle_time == '0) begin
                    if (cur.calc_done && cur.changed)
                        next_cur.msg[i].armed = 1'b1;
                end else begin
                    if (expire)
                        next_cur.msg[i].armed = 1'b1;
                    if (cur.msg[i].inhibit != '0 && cur.calc_done && cur.changed)
                        next_cur.msg[i].armed = 1'b1;
                end
            end
            if (cur.msg[i].dis) begin
                next_cur.msg[i].wait_calc = 1'b0;
                next_cur.msg[i].armed = 1'b0;
            end
        end

        if (cur.tx.valid && tx_ready)
            next_cur.tx.valid = 1'b0;
        // One message at a time; the first message wins a tie
        if (!next_cur.tx.valid) begin
            for (int i = 0; i < NMSG; i++) begin
                if (!found && next_cur.msg[i].armed && next_cur.msg[i].inh_cnt == '0) begin
                    found = 1'b1;
                    next_cur.tx.valid = 1'b1;
                    next_cur.tx.msg = 1'(i);
                    next_cur.tx.cob = cur.msg[i].cob;
                    next_cur.tx.data = cur.msg[i].use_latch ? cur.msg[i].latched
                                                            : cur.position;
                    next_cur.msg[i].armed = 1'b0;
                    next_cur.msg[i].use_latch = 1'b0;
                    // One extra unit covers the partial first tick of the gap
                    next_cur.msg[i].inh_cnt = {1'b0, cur.msg[i].inhibit}
                        + ((cur.msg[i].inhibit != '0) ? 17'h00001 : 17'h00000);
                end
            end
        end

        if (obj_req.wr || obj_req.rd) begin
            next_cur.ack = 1'b1;
            next_cur.rdata = '0;
            if (obj_req.index == OBJ_MSG1 || obj_req.index == OBJ_MSG2) begin
                for (int i = 0; i < NMSG; i++) begin
                    if (obj_req.index == ((i == 0) ? OBJ_MSG1 : OBJ_MSG2)) begin
                        unique case (obj_req.sub)
                            SUB_COUNT: begin
                                next_cur.rdata = SUB_COUNT_VAL;
                                next_cur.err = obj_req.wr;
                            end
                            SUB_COBID: begin
                                next_cur.rdata = {cur.msg[i].dis, COB_RTR_FIXED,
                                                  {COB_RSV_W{1'b0}}, cur.msg[i].cob};
                                if (obj_req.wr) begin
                                    next_cur.msg[i].dis = obj_req.wdata[COB_DIS_BIT];
                                    next_cur.msg[i].cob = obj_req.wdata[COB_ID_W-1:0];
                                end
                            end
                            SUB_MODE: begin
                                next_cur.rdata = {24'h000000, cur.msg[i].mode};
                                if (obj_req.wr) begin
                                    next_cur.msg[i].mode = obj_req.wdata[7:0];
                                    next_cur.msg[i].sync_cnt = '0;
                                end
                            end
                            SUB_INHIBIT: begin
                                next_cur.rdata = {16'h0000, cur.msg[i].inhibit};
                                if (obj_req.wr)
                                    next_cur.msg[i].inhibit = obj_req.wdata[15:0];
                            end
                            default: next_cur.err = 1'b1;
                        endcase
                    end
                end
            end else if (obj_req.index == OBJ_CYCLE && obj_req.sub == SUB_COUNT) begin
                next_cur.rdata = {16'h0000, cur.cycle_time};
                if (obj_req.wr) begin
                    next_cur.cycle_time = obj_req.wdata[15:0];
                    next_cur.cyc_cnt = '0;
                end
            end else if (obj_req.index == OBJ_SAVE && obj_req.sub == SUB_SAVE) begin
                next_cur.rdata = SAVE_INFO;
                // Only the exact code word commits, guarding against stray writes
                if (obj_req.wr && obj_req.wdata == SAVE_WORD) begin
                    next_cur.nv_we = 1'b1;
                    next_cur.nv_wdata = cur.msg[0].inhibit;
                end
            end else begin
                next_cur.err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
            cur.boot <= BOOT_FETCH;
            cur.msg[0].dis <= DIS_DEF1;
            cur.msg[0].mode <= MODE_DEF1;
            cur.msg[0].cob <= COB_BASE1;
            cur.msg[0].inhibit <= INHIBIT_DEF;
            cur.msg[1].dis <= DIS_DEF2;
            cur.msg[1].mode <= MODE_DEF2;
            cur.msg[1].cob <= COB_BASE2;
            cur.msg[1].inhibit <= INHIBIT_DEF;
        end else begin
            cur <= next_cur;
        end
    end

    assign obj_rdata   = cur.rdata;
    assign obj_ack     = cur.ack;
    assign obj_err     = cur.err;
    assign disc_sample = cur.sample;
    assign tx          = cur.tx;
endmodule // pdts_scheduler
`default_nettype wire

// File: logic/pdts_pkg.sv
// What this block does
// - First message enable is bit 31 of its identifier entry, 0 enabled, reset restores it.
// - First message transfer mode defaults to FEh and reverts to it on every reset.
// - First message inhibit time is stored in non-volatile memory on the save command.
// - Mode 0 sends on a SYNC only if the value changed since the previous SYNC.
// - Mode N of 1 to 240 sends on every Nth SYNC; codes 241 to 251 do nothing.
// - Mode 252 latches the value on SYNC and sends the latched value on remote request.
// - Mode 253 updates and sends the value only on remote request.
// - Mode 254 sends on change when cycle time is zero, else on cycle expiry and, with nonzero inhibit, also on change.
// - SYNC or remote request triggered messages wait for the running position calculation, except a remote request in modes 254 and 255, which sends at once.
// - The disc is sampled once per millisecond and positions computed after each sample.
// - Nonzero cycle and inhibit time send periodically and also immediately on change.
// - Zero cycle and inhibit send on every change; nonzero cycle, zero inhibit, only periodic.
// - Zero cycle time with nonzero inhibit sends on change with inhibit as minimum gap.
// - Second message is SYNC and remote request driven in modes 0 to 240, 252 and 253, like the first in 254 and 255; inhibit sets minimum gap between sends.
// - Second identifier: 280h plus node, bits 11-29 zero, bit 30 zero, bit 31 default disabled.
// - Second message transfer mode defaults to 01h and reverts to it after reset.
// - Second message inhibit time is zero after reset.
// - Inhibit time counts in 0.1 ms units as the least gap before resending.
// - First identifier defaults to 180h plus node number, remote bit fixed at zero.
package pdts_pkg;
    localparam int CLK_NS            = 50;
    localparam int SAMPLE_PERIOD_US  = 1000;
    localparam int INHIBIT_UNIT_US   = 100;
    localparam int CALC_TIME_US      = 800;
    localparam int SAMPLE_CYCLES_DEF = (SAMPLE_PERIOD_US * 1000) / CLK_NS;
    localparam int INHIBIT_CYCLES_DEF = (INHIBIT_UNIT_US * 1000) / CLK_NS;
    localparam int CALC_CYCLES_DEF   = (CALC_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;

    localparam int NMSG      = 2;
    localparam int NODE_W    = 5;
    localparam int COB_ID_W  = 11;
    localparam int COB_RSV_W = 19;
    localparam int CNT_W     = 24;
    localparam int NV_W      = 16;
    localparam int NV_DEPTH  = 2;
    localparam int NV_AW     = 1;

    localparam logic [15:0] OBJ_SAVE    = 16'h1010;
    localparam logic [15:0] OBJ_MSG1    = 16'h1800;
    localparam logic [15:0] OBJ_MSG2    = 16'h1802;
    localparam logic [15:0] OBJ_CYCLE   = 16'h6200;
    localparam logic [7:0]  SUB_COUNT   = 8'h00;
    localparam logic [7:0]  SUB_COBID   = 8'h01;
    localparam logic [7:0]  SUB_MODE    = 8'h02;
    localparam logic [7:0]  SUB_INHIBIT = 8'h03;
    localparam logic [7:0]  SUB_SAVE    = 8'h01;
    localparam logic [31:0] SAVE_WORD   = 32'h65766173;
    localparam logic [31:0] SAVE_INFO   = 32'h00000001;
    localparam logic [31:0] SUB_COUNT_VAL = 32'h00000003;
    localparam int          COB_DIS_BIT = 31;
    localparam logic        COB_RTR_FIXED = 1'b0;

    localparam logic [COB_ID_W-1:0] COB_BASE1 = 11'h180;
    localparam logic [COB_ID_W-1:0] COB_BASE2 = 11'h280;
    localparam logic [7:0]  MODE_DEF1   = 8'hfe;
    localparam logic [7:0]  MODE_DEF2   = 8'h01;
    localparam logic [15:0] INHIBIT_DEF = 16'h0000;
    localparam logic        DIS_DEF1    = 1'b0;
    localparam logic        DIS_DEF2    = 1'b1;
    localparam logic [7:0]  MODE_SYNC_CHG = 8'h00;
    localparam logic [7:0]  MODE_CYC_MAX  = 8'hf0;
    localparam logic [7:0]  MODE_RSV_MAX  = 8'hfb;
    localparam logic [7:0]  MODE_LATCH    = 8'hfc;
    localparam logic [7:0]  MODE_RTR      = 8'hfd;
    localparam logic [NV_AW-1:0] NV_SLOT_INHIBIT1 = 1'b0;

    typedef enum logic [2:0] {
        MC_SYNC_CHG, MC_SYNC_CYC, MC_RESERVED, MC_SYNC_LATCH, MC_RTR, MC_ASYNC
    } pdts_mode_e;

    typedef enum logic [1:0] {BOOT_FETCH, BOOT_LOAD, BOOT_RUN} pdts_boot_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } pdts_obj_req_s;

    typedef struct packed {
        logic                valid;
        logic                msg;
        logic [COB_ID_W-1:0] cob;
        logic [31:0]         data;
    } pdts_tx_s;

    typedef struct packed {
        logic                dis;
        logic [COB_ID_W-1:0] cob;
        logic [7:0]          mode;
        logic [15:0]         inhibit;
        logic [16:0]         inh_cnt;
        logic [7:0]          sync_cnt;
        logic                wait_calc;
        logic                armed;
        logic                use_latch;
        logic [31:0]         latched;
        logic [31:0]         last_sync;
    } pdts_msg_s;

    function automatic pdts_mode_e pdts_mode_class(input logic [7:0] code);
        if (code == MODE_SYNC_CHG)
            return MC_SYNC_CHG;
        else if (code <= MODE_CYC_MAX)
            return MC_SYNC_CYC;
        else if (code <= MODE_RSV_MAX)
            return MC_RESERVED;
        else if (code == MODE_LATCH)
            return MC_SYNC_LATCH;
        else if (code == MODE_RTR)
            return MC_RTR;
        else
            return MC_ASYNC;
    endfunction
endpackage

// File: logic/pdts_tick.sv
`timescale 1ns/1ps
`default_nettype none
module pdts_tick #(
    parameter int PERIOD = 2000
) (
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      tick
);
    localparam int CW = $clog2(PERIOD + 1);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } pdts_tick_s;

    pdts_tick_s cur;
    pdts_tick_s next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (cur.cnt == CW'(PERIOD - 1)) begin
            next_cur.cnt = '0;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.cnt = cur.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign tick = cur.tick;
endmodule // pdts_tick
`default_nettype wire

// File: logic/pdts_nvmem.sv
`timescale 1ns/1ps
`default_nettype none
// Stands for the non-volatile store: contents survive reset_n on purpose.
module pdts_nvmem #(
    parameter int W     = 16,
    parameter int DEPTH = 2,
    parameter int AW    = 1
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [W-1:0]       rdata
);
    logic [W-1:0] mem [DEPTH] = '{default: '0};

    always_ff @(posedge clk) begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule // pdts_nvmem
`default_nettype wire

// File: verif/pdts_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pdts_checker
    import pdts_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
    input wire logic          clk,
    input wire logic          reset_n,
    input wire pdts_obj_req_s obj_req,
    input wire logic [31:0]   obj_rdata,
    input wire logic          obj_ack,
    input wire logic          obj_err,
    input wire logic          disc_sample,
    input wire pdts_tx_s      tx,
    input wire logic          tx_ready
);
    logic [31:0] gap;
    logic        seen;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_req;
        obj_req.wr || obj_req.rd;
    endsequence
    sequence s_sub0_wr;
        obj_req.wr && obj_req.sub == SUB_COUNT && obj_req.index != OBJ_CYCLE;
    endsequence
    sequence s_cob2_rd;
        obj_req.rd && obj_req.index == OBJ_MSG2 && obj_req.sub == SUB_COBID;
    endsequence
    // Counts edges between capture pulses to pin the sampling rate down exactly
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap  <= '0;
            seen <= 1'b0;
        end else begin
            gap  <= disc_sample ? '0 : gap + 32'd1;
            seen <= seen | disc_sample;
        end
    end
    a_req_acked: assert property (s_req |=> obj_ack)
        else $error("access not answered next cycle");
    a_no_stray_ack: assert property (!(obj_req.wr || obj_req.rd) |=> !obj_ack)
        else $error("answer without access");
    // A refused count-entry write still shows the entry count; other refusals read zero
    a_err_has_ack: assert property (obj_err |-> obj_ack
        && (obj_rdata == '0 || $past(obj_req.sub) == SUB_COUNT))
        else $error("refusal without answer or with data");
    a_sub0_refused: assert property (s_sub0_wr |=> obj_err)
        else $error("count entry write accepted");
    a_cob_rsv_zero: assert property (s_cob2_rd |=> obj_rdata[30:11] == '0)
        else $error("identifier reserved bits not zero");
    a_tx_held: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx))
        else $error("frame changed while waiting");
    a_tick_exact: assert property (disc_sample && seen |-> gap == SAMPLE_CYCLES - 1)
        else $error("sample spacing wrong");
    a_tick_due: assert property (!seen || gap < SAMPLE_CYCLES)
        else $error("sample overdue");
    a_sample_pulse: assert property (disc_sample |=> !disc_sample[*8])
        else $error("sample pulse too long");
endmodule // pdts_checker
bind pdts_scheduler pdts_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_checker (
    .clk(clk), .reset_n(reset_n), .obj_req(obj_req), .obj_rdata(obj_rdata),
    .obj_ack(obj_ack), .obj_err(obj_err), .disc_sample(disc_sample), .tx(tx),
    .tx_ready(tx_ready));
`default_nettype wire

// File: verif/pdts_master.sv
`timescale 1ns/1ps
`default_nettype none
module pdts_master (
    input  wire logic clk,
    output logic      sync_rx,
    output logic      rtr_rx,
    output logic      rtr_msg,
    output logic      tx_ready
);
    integer seed = 32'hd30e;
    initial begin
        sync_rx  = 1'b0;
        rtr_rx   = 1'b0;
        rtr_msg  = 1'b0;
        tx_ready = 1'b0;
    end
    // A busy bus takes frames late; stall about one edge in four
    always @(posedge clk) tx_ready <= ($random(seed) % 4) != 0;
    task automatic sync();
        @(posedge clk);
        sync_rx <= 1'b1;
        @(posedge clk);
        sync_rx <= 1'b0;
    endtask
    task automatic rtr(input logic sel);
        @(posedge clk);
        rtr_rx  <= 1'b1;
        rtr_msg <= sel;
        @(posedge clk);
        rtr_rx  <= 1'b0;
        rtr_msg <= ~sel;
    endtask
endmodule // pdts_master
`default_nettype wire

// File: verif/pdts_scheduler_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pdts_scheduler_bench;
    import pdts_pkg::*;
    localparam int SC = 200;
    logic          clk, reset_n, sync_rx, rtr_rx, rtr_msg, tx_ready, obj_ack, obj_err;
    logic          disc_sample, quiet;
    logic [4:0]    node_id;
    logic [31:0]   obj_rdata, disc_position, p, q;
    pdts_obj_req_s obj_req;
    pdts_tx_s      tx;
    integer        seed = 32'hd30e;
    int            n_fail = 0;
    int            samples_checked = 0;
    logic [64:0]   oq[$];
    logic [43:0]   tq[$];
    pdts_master u_master (.clk(clk), .sync_rx(sync_rx), .rtr_rx(rtr_rx), .rtr_msg(rtr_msg),
        .tx_ready(tx_ready));
    pdts_scheduler #(.SAMPLE_CYCLES(SC), .CALC_CYCLES(100), .INHIBIT_CYCLES(20)) dut (
        .clk(clk), .reset_n(reset_n), .node_id(node_id), .sync_rx(sync_rx), .rtr_rx(rtr_rx),
        .rtr_msg(rtr_msg), .obj_req(obj_req), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
        .obj_err(obj_err), .disc_position(disc_position), .disc_sample(disc_sample),
        .tx(tx), .tx_ready(tx_ready));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic fail(input string m);
        n_fail++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic chk_obj(input logic [64:0] e);
        samples_checked++;
        if (obj_err !== e[64] || (obj_rdata & e[63:32]) !== (e[31:0] & e[63:32]))
            fail("object answer");
    endtask
    task automatic chk_tx(input logic [43:0] e);
        samples_checked++;
        if ({tx.msg, tx.cob, tx.data} !== e) fail("frame");
    endtask
    always @(posedge clk) begin
        if (reset_n === 1'b1 && obj_ack === 1'b1) begin
            if (oq.size() == 0) fail("stray answer");
            else chk_obj(oq.pop_front());
        end
        if (reset_n === 1'b1 && quiet === 1'b0 && tx.valid === 1'b1 && tx_ready === 1'b1) begin
            if (tq.size() == 0) fail("unexpected frame");
            else chk_tx(tq.pop_front());
        end
    end
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [31:0] d, input logic e, input logic [31:0] m);
        @(posedge clk);
        obj_req <= '{wr: w, rd: !w, index: i, sub: s, wdata: d};
        oq.push_back({e, m, d});
        @(posedge clk);
        obj_req <= '0;
    endtask
    task automatic frame(input logic m, input logic [31:0] d);
        tq.push_back({m, (m ? 11'h280 : 11'h180) + 11'(node_id), d});
    endtask
    // Response may lag a full calculation, so allow two sample periods
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        if (tq.size() != 0) fail("frame missing");
        tq.delete();
    endtask
    task automatic posn(input logic m);
        p = $random(seed);
        @(posedge clk);
        disc_position <= p;
        if (m) frame(1'b0, p);
        settle(2 * SC);
    endtask
    task automatic boot();
        quiet <= 1'b1;
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3 * SC) @(posedge clk);
        quiet <= 1'b0;
    endtask
    task automatic summarize();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fail("watchdog");
        summarize();
    end
    initial begin
        reset_n = 1'b0;
        quiet = 1'b1;
        obj_req = '0;
        disc_position = 32'h0000_1234;
        node_id = 5'd1 + 5'($unsigned($random(seed)) % 31);
        boot();
        acc(0, 16'h1800, 8'h01, 32'h180 + node_id, 0, '1);
        acc(0, 16'h1800, 8'h02, 32'hfe, 0, '1);
        acc(0, 16'h1802, 8'h01, 32'h8000_0280 + node_id, 0, '1);
        acc(0, 16'h1802, 8'h02, 32'h01, 0, '1);
        acc(0, 16'h1802, 8'h03, 32'h0, 0, '1);
        acc(0, 16'h1802, 8'h07, 32'h0, 1, '1);
        acc(1, 16'h1802, 8'h00, 32'h0, 1, 0);
        u_master.sync();
        u_master.rtr(1'b1);
        settle(2 * SC);
        acc(1, 16'h1800, 8'h03, 32'h0, 0, 0);
        for (int c = 254; c <= 255; c++) begin
            acc(1, 16'h1800, 8'h02, 32'(c), 0, 0);
            posn(1'b1);
        end
        acc(1, 16'h1800, 8'h01, 32'h8000_0180 + node_id, 0, 0);
        acc(1, 16'h1802, 8'h01, 32'h280 + node_id, 0, 0);
        frame(1'b1, disc_position);
        u_master.sync();
        settle(2 * SC);
        acc(1, 16'h1802, 8'h02, 32'h3, 0, 0);
        for (int k = 1; k <= 3; k++) begin
            if (k == 3) frame(1'b1, disc_position);
            u_master.sync();
            settle(2 * SC);
        end
        for (int c = 241; c <= 251; c++) begin
            acc(1, 16'h1802, 8'h02, 32'(c), 0, 0);
            u_master.sync();
            u_master.rtr(1'b1);
            settle(2 * SC);
        end
        acc(1, 16'h1802, 8'h02, 32'hfc, 0, 0);
        u_master.sync();
        settle(2 * SC);
        q = disc_position;
        posn(1'b0);
        frame(1'b1, q);
        u_master.rtr(1'b1);
        settle(2 * SC);
        acc(1, 16'h1802, 8'h02, 32'hfd, 0, 0);
        u_master.sync();
        settle(2 * SC);
        posn(1'b0);
        frame(1'b1, disc_position);
        u_master.rtr(1'b1);
        settle(2 * SC);
        acc(1, 16'h1802, 8'h02, 32'h0, 0, 0);
        frame(1'b1, disc_position);
        u_master.sync();
        settle(2 * SC);
        u_master.sync();
        settle(2 * SC);
        posn(1'b0);
        frame(1'b1, disc_position);
        u_master.sync();
        settle(2 * SC);
        acc(1, 16'h1800, 8'h03, 32'h7, 0, 0);
        acc(1, 16'h1010, 8'h01, 32'h6576_6173, 0, 0);
        // Let the answer and the store write land before the reset cuts them off
        repeat (2) @(posedge clk);
        node_id <= 5'd1 + 5'($unsigned($random(seed)) % 31);
        boot();
        acc(0, 16'h1800, 8'h03, 32'h7, 0, '1);
        acc(0, 16'h1800, 8'h01, 32'h180 + node_id, 0, '1);
        acc(0, 16'h1802, 8'h01, 32'h8000_0280 + node_id, 0, '1);
        acc(0, 16'h1802, 8'h02, 32'h01, 0, '1);
        acc(1, 16'h6200, 8'h00, 32'h3, 0, 0);
        repeat (2) frame(1'b0, disc_position);
        settle(7 * SC);
        repeat (4) @(posedge clk);
        summarize();
    end
endmodule // pdts_scheduler_bench
`default_nettype wire
